// ===== hw/sfp_host.sv
// host controller driving a byte-wide sector flash through its pins
// assumes flash data pins arrive asynchronously; one 125 MHz clock, synchronous reset
`timescale 1ns/1ps
module sfp_host import sfp_pkg::*; #(
    parameter int GAP_CYC_P = GAP_CYC,
    parameter int PROG_CYC_P = PROG_CYC
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic op_valid,
    output logic op_ready,
    input wire logic [1:0] op_code,
    input wire logic [ADDR_W-1:0] op_addr,
    input wire logic [7:0] op_len,
    input wire logic wr_valid,
    output logic wr_ready,
    input wire logic [DATA_W-1:0] wr_data,
    output logic rsp_valid,
    output logic [15:0] rsp_data,
    output logic rsp_err,
    output logic [ADDR_W-1:0] fl_addr,
    output logic fl_ce_n,
    output logic fl_oe_n,
    output logic fl_we_n,
    output logic [DATA_W-1:0] fl_dq_o,
    output logic fl_dq_oe_n,
    input wire logic [DATA_W-1:0] fl_dq_i
);
    localparam int GW = $clog2(GAP_CYC_P + 1);
    localparam int TW = $clog2(PROG_CYC_P + 1);
    localparam int GAP_STOP = GAP_CYC_P - AS_CYC - 1;
    if (GAP_STOP <= AS_CYC + WP_CYC + HI_CYC) begin : g_chk
        $error("byte load gap too short for one bus write");
    end
    typedef enum logic [2:0] {ST_IDLE, ST_SEQ, ST_LOAD, ST_POLL, ST_IDRD, ST_READ, ST_RESP} sfp_st_e;
    typedef enum logic [1:0] {BP_IDLE, BP_SET, BP_STB, BP_HI} sfp_bp_e;
    sfp_st_e st_r;
    sfp_bp_e ph_r;
    sfp_seq_e seq_kind_r;
    logic [1:0] seq_step_r;
    logic [SEC_W-1:0] sector_r;
    logic [SEC_LSB-1:0] off_r;
    logic [7:0] left_r;
    logic [ADDR_W-1:0] addr_r;
    logic [ADDR_W-1:0] poll_a_r;
    logic [GW-1:0] gap_r;
    logic [TW-1:0] prog_wait_r;
    logic prev_r;
    logic have_prev_r;
    logic err_r;
    logic id_sel_r;
    logic [15:0] res_r;
    logic rsp_valid_r;
    logic [7:0] cnt_r;
    logic wr_r;
    logic [DATA_W-1:0] dq_s1_r, dq_s2_r, dq_s3_r;
    logic [DATA_W-1:0] bus_rdata_r;
    sfp_strm_if #(.W(DATA_W)) in_s ();
    sfp_strm_if #(.W(DATA_W)) buf_s ();
    // ==========================================================
    // write data buffer
    assign in_s.valid = wr_valid;
    assign in_s.data = wr_data;
    assign wr_ready = in_s.ready;
    sfp_buf2 #(.W(DATA_W), .DEPTH(2)) u_buf (
        .clock(clock),
        .srst(srst),
        .up(in_s),
        .dn(buf_s)
    );
    // ==========================================================
    // request decode and bus selection
    wire bus_idle = (ph_r == BP_IDLE);
    wire bus_done = (ph_r == BP_HI) && (cnt_r == 8'h00);
    // flash still loads until a full gap has passed; earlier polls would see old data
    wire poll_go = (st_r == ST_POLL) && (gap_r == GW'(GAP_CYC_P));
    wire need_bus = (st_r == ST_SEQ) || poll_go || (st_r == ST_IDRD) || (st_r == ST_READ)
        || (st_r == ST_LOAD && buf_s.valid);
    wire bus_go = bus_idle && need_bus;
    wire go_wr = (st_r == ST_SEQ) || (st_r == ST_LOAD);
    wire [14:0] seq_a = (seq_step_r == 2'h1) ? CMD_A2 : CMD_A1;
    wire [7:0] seq_code = (seq_kind_r == SFP_SEQ_PROT) ? CMD_PROT :
        (seq_kind_r == SFP_SEQ_ID_IN) ? CMD_ID_IN : CMD_ID_OUT;
    wire [7:0] seq_d = (seq_step_r == 2'h0) ? CMD_D1 : (seq_step_r == 2'h1) ? CMD_D2 : seq_code;
    wire [ADDR_W-1:0] load_a = {sector_r, off_r};
    wire [ADDR_W-1:0] go_addr = (st_r == ST_SEQ) ? {2'b00, seq_a} :
        (st_r == ST_LOAD) ? load_a :
        (st_r == ST_POLL) ? poll_a_r :
        (st_r == ST_IDRD) ? {{(ADDR_W-1){1'b0}}, id_sel_r} : addr_r;
    wire [DATA_W-1:0] go_data = (st_r == ST_SEQ) ? seq_d : buf_s.data;
    assign buf_s.ready = bus_go && (st_r == ST_LOAD);
    wire load_last = (left_r == 8'h01) || (off_r == SEC_LSB'(SEC_BYTES - 1));
    wire gap_out = (st_r == ST_LOAD) && !buf_s.valid && (gap_r >= GW'(GAP_STOP));
    wire dq_stable = (dq_s2_r == dq_s3_r);
    wire tgl_now = bus_rdata_r[TOGGLE_BIT];
    wire poll_same = have_prev_r && (tgl_now == prev_r);
    assign op_ready = (st_r == ST_IDLE);
    assign rsp_valid = rsp_valid_r;
    assign rsp_data = res_r;
    assign rsp_err = err_r;
    // ==========================================================
    // pin input synchroniser
    always_ff @(posedge clock) begin
        if (srst) begin
            dq_s1_r <= '0;
            dq_s2_r <= '0;
            dq_s3_r <= '0;
        end else begin
            dq_s1_r <= fl_dq_i;
            dq_s2_r <= dq_s1_r;
            dq_s3_r <= dq_s2_r;
        end
    end
    // ==========================================================
    // bus cycle engine: setup, strobe, strobe-high recovery
    always_ff @(posedge clock) begin
        if (srst) begin
            ph_r <= BP_IDLE;
            cnt_r <= '0;
            wr_r <= 1'b0;
            fl_addr <= '0;
            fl_dq_o <= '0;
            fl_dq_oe_n <= 1'b1;
            fl_ce_n <= 1'b1;
            fl_oe_n <= 1'b1;
            fl_we_n <= 1'b1;
            bus_rdata_r <= '0;
        end else begin
            unique case (ph_r)
                BP_IDLE: if (bus_go) begin
                    ph_r <= BP_SET;
                    cnt_r <= 8'(AS_CYC - 1);
                    wr_r <= go_wr;
                    fl_addr <= go_addr;
                    fl_dq_o <= go_data;
                    fl_dq_oe_n <= !go_wr;
                    fl_ce_n <= 1'b0;
                end
                BP_SET: if (cnt_r == 8'h00) begin
                    ph_r <= BP_STB;
                    // output strobe stays high whenever write strobe is low
                    cnt_r <= wr_r ? 8'(WP_CYC - 1) : 8'(ACC_CYC + SYNC_CYC - 1);
                    fl_we_n <= !wr_r;
                    fl_oe_n <= wr_r;
                end else begin
                    cnt_r <= cnt_r - 8'h01;
                end
                BP_STB: if (cnt_r == 8'h00 && (wr_r || dq_stable)) begin
                    ph_r <= BP_HI;
                    cnt_r <= 8'(HI_CYC - 1);
                    fl_we_n <= 1'b1;
                    fl_oe_n <= 1'b1;
                    fl_ce_n <= 1'b1;
                    if (!wr_r) begin
                        bus_rdata_r <= dq_s3_r;
                    end
                end else if (cnt_r != 8'h00) begin
                    cnt_r <= cnt_r - 8'h01;
                end
                BP_HI: if (cnt_r == 8'h00) begin
                    ph_r <= BP_IDLE;
                    fl_dq_oe_n <= 1'b1;
                end else begin
                    cnt_r <= cnt_r - 8'h01;
                end
            endcase
        end
    end
    // ==========================================================
    // gap and write cycle timers
    always_ff @(posedge clock) begin
        if (srst || (st_r != ST_LOAD && st_r != ST_POLL) || buf_s.ready) begin
            gap_r <= '0;
        end else if (gap_r != GW'(GAP_CYC_P)) begin
            gap_r <= gap_r + 1'b1;
        end
    end
    // flash finishes alone; only a toggle bit that keeps toggling runs this out
    always_ff @(posedge clock) begin
        if (srst || st_r != ST_POLL) begin
            prog_wait_r <= '0;
        end else if (prog_wait_r != TW'(PROG_CYC_P)) begin
            prog_wait_r <= prog_wait_r + 1'b1;
        end
    end
    // ==========================================================
    // operation sequencer
    always_ff @(posedge clock) begin
        if (srst) begin
            st_r <= ST_IDLE;
            seq_kind_r <= SFP_SEQ_PROT;
            seq_step_r <= '0;
            sector_r <= '0;
            off_r <= '0;
            left_r <= '0;
            addr_r <= '0;
            poll_a_r <= '0;
            prev_r <= 1'b0;
            have_prev_r <= 1'b0;
            err_r <= 1'b0;
            id_sel_r <= 1'b0;
            res_r <= '0;
            rsp_valid_r <= 1'b0;
        end else begin
            rsp_valid_r <= 1'b0;
            unique case (st_r)
                ST_IDLE: if (op_valid) begin
                    addr_r <= op_addr;
                    sector_r <= op_addr[ADDR_W-1:SEC_LSB];
                    off_r <= op_addr[SEC_LSB-1:0];
                    left_r <= (op_len == 8'h00) ? 8'h01 : op_len;
                    err_r <= 1'b0;
                    have_prev_r <= 1'b0;
                    id_sel_r <= 1'b0;
                    seq_step_r <= '0;
                    // identification always opens with its entry sequence
                    seq_kind_r <= (op_code == SFP_OP_IDENT) ? SFP_SEQ_ID_IN : SFP_SEQ_PROT;
                    st_r <= (op_code == SFP_OP_READ) ? ST_READ : ST_SEQ;
                end
                ST_SEQ: if (bus_done) begin
                    seq_step_r <= seq_step_r + 2'h1;
                    if (seq_step_r == SEQ_LAST) begin
                        seq_step_r <= '0;
                        st_r <= (seq_kind_r == SFP_SEQ_PROT) ? ST_LOAD :
                            (seq_kind_r == SFP_SEQ_ID_IN) ? ST_IDRD : ST_RESP;
                    end
                end
                ST_LOAD: if (bus_done) begin
                    poll_a_r <= load_a;
                    off_r <= off_r + 1'b1;
                    left_r <= left_r - 8'h01;
                    // untouched bytes of the sector come back undefined
                    if (load_last) begin
                        st_r <= ST_POLL;
                    end
                end else if (gap_out) begin
                    err_r <= 1'b1;
                    st_r <= ST_POLL;
                end
                ST_POLL: if (bus_done) begin
                    prev_r <= tgl_now;
                    have_prev_r <= 1'b1;
                    res_r <= {8'h00, bus_rdata_r};
                    if (poll_same) begin
                        st_r <= ST_RESP;
                    end
                end else if (prog_wait_r == TW'(PROG_CYC_P)) begin
                    err_r <= 1'b1;
                    st_r <= ST_RESP;
                end
                ST_IDRD: if (bus_done) begin
                    id_sel_r <= 1'b1;
                    if (id_sel_r) begin
                        res_r[7:0] <= bus_rdata_r;
                        seq_kind_r <= SFP_SEQ_ID_OUT;
                        st_r <= ST_SEQ;
                    end else begin
                        res_r[15:8] <= bus_rdata_r;
                    end
                end
                ST_READ: if (bus_done) begin
                    res_r <= {8'h00, bus_rdata_r};
                    st_r <= ST_RESP;
                end
                ST_RESP: begin
                    rsp_valid_r <= 1'b1;
                    st_r <= ST_IDLE;
                end
            endcase
        end
    end
    // ==========================================================
    // checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);
    a_sector_held: assert property ((st_r == ST_LOAD && $fell(fl_we_n)) |-> fl_addr[ADDR_W-1:SEC_LSB] == sector_r)
        else $error("byte load left its sector");
    a_cmd_addr_low: assert property ((st_r == ST_SEQ && $fell(fl_we_n)) |-> fl_addr[ADDR_W-1:15] == 2'b00)
        else $error("command write used upper address bits");
    a_gap_limit: assert property ((st_r == ST_LOAD) |-> gap_r < GW'(GAP_CYC_P))
        else $error("byte load gap exceeded");
    a_poll_addr_fixed: assert property ((st_r == ST_POLL && $fell(fl_oe_n)) |-> fl_addr == poll_a_r)
        else $error("polling address moved");
    a_id_addr_low: assert property ((st_r == ST_IDRD && $fell(fl_oe_n)) |-> fl_addr[ADDR_W-1:1] == '0)
        else $error("identification read with upper address set");
    a_exit_code: assert property ((st_r == ST_SEQ && seq_kind_r == SFP_SEQ_ID_OUT && seq_step_r == SEQ_LAST
        && $fell(fl_we_n)) |-> fl_dq_o == CMD_ID_OUT && !fl_dq_oe_n)
        else $error("exit sequence ended with wrong code");
    a_poll_stop: assert property ((st_r == ST_POLL && bus_done && poll_same) |=> st_r == ST_RESP ##1 rsp_valid)
        else $error("steady toggle bit not taken as done");
    a_prog_bound: assert property ((st_r == ST_POLL) |-> prog_wait_r <= TW'(PROG_CYC_P))
        else $error("write cycle wait overran");
    a_poll_wait: assert property ((st_r == ST_POLL && $fell(fl_oe_n)) |-> gap_r == GW'(GAP_CYC_P))
        else $error("polling began inside the byte load window");
    a_id_entry_first: assert property ($rose(st_r == ST_IDRD) |-> $past(seq_kind_r) == SFP_SEQ_ID_IN)
        else $error("identification read without entry sequence");
    a_strobe_excl: assert property (!(!fl_oe_n && !fl_we_n))
        else $error("output and write strobes low together");
    a_we_width: assert property ($fell(fl_we_n) |-> (!fl_we_n) [*8])
        else $error("write pulse too short");
    c_prog_ok: cover property (st_r == ST_POLL && bus_done && poll_same);
    c_ident: cover property (st_r == ST_IDRD && bus_done && id_sel_r);
    c_read: cover property (st_r == ST_READ && bus_done);
    c_underrun: cover property (gap_out);
endmodule // sfp_host

// ===== hw/sfp_pkg.sv
// constants shared by the sector flash host controller and its parts
// assumes a 125 MHz system clock and a byte-wide asynchronous flash outside
package sfp_pkg;
    // ==========================================================
    // clock and timing
    localparam int CLK_MHZ = 125;
    localparam int T_AS_NS = 10;
    localparam int T_WP_NS = 200;
    localparam int T_WPH_NS = 200;
    localparam int T_ACC_NS = 120;
    localparam int T_OEHP_NS = 150;
    localparam int GAP_US = 150;
    localparam int PROG_MS = 20;
    localparam int AS_CYC = (T_AS_NS * CLK_MHZ + 999) / 1000;
    localparam int WP_CYC = (T_WP_NS * CLK_MHZ + 999) / 1000;
    localparam int ACC_CYC = (T_ACC_NS * CLK_MHZ + 999) / 1000;
    localparam int HI_NS = (T_WPH_NS > T_OEHP_NS) ? T_WPH_NS : T_OEHP_NS;
    localparam int HI_CYC = (HI_NS * CLK_MHZ + 999) / 1000;
    // longest gap rounds down, least write cycle wait rounds up
    localparam int GAP_CYC = GAP_US * CLK_MHZ;
    localparam int PROG_CYC = PROG_MS * 1000 * CLK_MHZ;
    localparam int SYNC_CYC = 3;
    // ==========================================================
    // pin layout
    localparam int ADDR_W = 17;
    localparam int DATA_W = 8;
    localparam int SEC_LSB = 7;
    localparam int SEC_W = ADDR_W - SEC_LSB;
    localparam int SEC_BYTES = 128;
    localparam int TOGGLE_BIT = 6;
    // ==========================================================
    // command sequences
    localparam logic [14:0] CMD_A1 = 15'h5555;
    localparam logic [14:0] CMD_A2 = 15'h2aaa;
    localparam logic [7:0] CMD_D1 = 8'haa;
    localparam logic [7:0] CMD_D2 = 8'h55;
    localparam logic [7:0] CMD_PROT = 8'ha0;
    localparam logic [7:0] CMD_ID_IN = 8'h90;
    localparam logic [7:0] CMD_ID_OUT = 8'hf0;
    localparam logic [1:0] SEQ_LAST = 2'h2;
    typedef enum logic [1:0] {SFP_OP_READ, SFP_OP_PROG, SFP_OP_IDENT} sfp_op_e;
    typedef enum logic [1:0] {SFP_SEQ_PROT, SFP_SEQ_ID_IN, SFP_SEQ_ID_OUT} sfp_seq_e;
endpackage

// ===== hw/sfp_strm_if.sv
// valid/ready byte stream between the controller and its buffer
// assumes both ends on the same clock
`timescale 1ns/1ps
interface sfp_strm_if #(parameter int W = 8);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

// ===== hw/sfp_buf2.sv
// two-entry buffer, full throughput, no combinational path from out ready to in ready
// assumes one clock and synchronous reset
`timescale 1ns/1ps
module sfp_buf2 #(
    parameter int W = 8,
    parameter int DEPTH = 2
) (
    input wire logic clock,
    input wire logic srst,
    sfp_strm_if.snk up,
    sfp_strm_if.src dn
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    if (DEPTH != 2) begin : g_chk
        $error("sfp_buf2 serves exactly two entries");
    end
    logic [W-1:0] mem_r [DEPTH];
    logic [PW-1:0] wptr_r;
    logic [PW-1:0] rptr_r;
    logic [PW:0] cnt_r;
    wire push = up.valid && up.ready;
    wire pop = dn.valid && dn.ready;
    assign up.ready = (cnt_r != (PW+1)'(DEPTH));
    assign dn.valid = (cnt_r != '0);
    assign dn.data = mem_r[rptr_r];
    // ==========================================================
    // storage, one slot per entry
    for (genvar i = 0; i < DEPTH; i++) begin : g_ent
        always_ff @(posedge clock) begin
            if (srst) begin
                mem_r[i] <= '0;
            end else if (push && wptr_r == PW'(i)) begin
                mem_r[i] <= up.data;
            end
        end
    end
    always_ff @(posedge clock) begin
        if (srst) begin
            wptr_r <= '0;
            rptr_r <= '0;
            cnt_r <= '0;
        end else begin
            wptr_r <= push ? wptr_r + 1'b1 : wptr_r;
            rptr_r <= pop ? rptr_r + 1'b1 : rptr_r;
            cnt_r <= cnt_r + (PW+1)'(push) - (PW+1)'(pop);
        end
    end
endmodule // sfp_buf2

// ===== dv/sfp_flash_model.sv
// behavioural byte-wide sector flash seen from its pins
// assumes pins move just after rising clock edges; clock only serves as a timebase
`timescale 1ns/1ps
module sfp_flash_model import sfp_pkg::*; #(
    parameter int GAP_CYC_M = 150,
    parameter logic [7:0] MAKER_ID = 8'h3c, // arbitrary
    parameter logic [7:0] PART_ID = 8'hc5 // arbitrary
) (
    input wire logic clock,
    input wire logic [31:0] busy_cyc,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic ce_n,
    input wire logic oe_n,
    input wire logic we_n,
    input wire logic [DATA_W-1:0] din,
    output logic [DATA_W-1:0] dout,
    output int viol_cnt
);
    // ==========================================================
    // storage and state
    logic [7:0] mem [0:(1<<ADDR_W)-1];
    logic [7:0] pbuf [0:SEC_BYTES-1];
    logic [SEC_BYTES-1:0] ld_r = '0;
    logic [SEC_W-1:0] sec_r = '0;
    logic [ADDR_W-1:0] poll_a_r = '0;
    logic [1:0] seq_r = 2'h0;
    logic idm_r = 1'b0;
    logic tog_r = 1'b0;
    logic loading_r = 1'b0, busy_r = 1'b0, wr_d = 1'b0, rd_d = 1'b0, polled_r = 1'b0;
    logic [7:0] last_r = 8'h00;
    int gap_r = 0, bcnt_r = 0, bad_r = 0;
    wire wr_on = ~ce_n & ~we_n & oe_n;
    wire rd_on = ~ce_n & ~oe_n & we_n;
    wire wr_end = wr_d & ~wr_on;
    wire [14:0] cmd_a = addr[14:0];
    wire id_sel = idm_r && addr[ADDR_W-1:1] == '0;
    wire [7:0] val = busy_r ? {1'b0, tog_r, 6'h2a} : id_sel ? (addr[0] ? PART_ID : MAKER_ID) : mem[addr];
    // released bus shows the inverse of the last byte, never a stale copy
    assign dout = rd_on ? val : ~last_r;
    assign viol_cnt = bad_r;
    initial for (int a = 0; a < (1<<ADDR_W); a++) mem[a] = 8'(a) ^ 8'(a >> 8) ^ 8'(a >> 16);
    // ==========================================================
    // strobe sequencing
    always @(posedge clock) begin
        wr_d <= wr_on;
        rd_d <= rd_on;
        if (rd_on) last_r <= val;
        if (loading_r) begin
            gap_r <= gap_r + 1;
            if (gap_r >= GAP_CYC_M) begin
                loading_r <= 1'b0;
                busy_r <= 1'b1;
                bcnt_r <= 0;
                polled_r <= 1'b0;
                for (int i = 0; i < SEC_BYTES; i++) mem[{sec_r, i[6:0]}] <= ld_r[i] ? pbuf[i] : 8'hxx;
            end
        end
        if (busy_r) begin
            bcnt_r <= bcnt_r + 1;
            if (bcnt_r >= busy_cyc) busy_r <= 1'b0;
            if (rd_d && !rd_on) begin
                tog_r <= ~tog_r;
                if (polled_r && addr != poll_a_r) bad_r <= bad_r + 1;
                polled_r <= 1'b1;
                poll_a_r <= addr;
            end
        end
        if (wr_end && loading_r) begin
            if (ld_r != '0 && addr[ADDR_W-1:SEC_LSB] != sec_r) bad_r <= bad_r + 1;
            if (ld_r == '0) sec_r <= addr[ADDR_W-1:SEC_LSB];
            pbuf[addr[6:0]] <= din;
            ld_r[addr[6:0]] <= 1'b1;
            gap_r <= 0;
        end else if (wr_end && !busy_r) begin
            if (seq_r == 2'h2 && cmd_a == CMD_A1 && din == CMD_PROT) begin
                loading_r <= 1'b1;
                ld_r <= '0;
                gap_r <= 0;
            end
            if (seq_r == 2'h2 && cmd_a == CMD_A1 && din == CMD_ID_IN) idm_r <= 1'b1;
            if (seq_r == 2'h2 && cmd_a == CMD_A1 && din == CMD_ID_OUT) idm_r <= 1'b0;
            seq_r <= (cmd_a == CMD_A1 && din == CMD_D1) ? 2'h1 :
                     (seq_r == 2'h1 && cmd_a == CMD_A2 && din == CMD_D2) ? 2'h2 : 2'h0;
        end
    end
endmodule // sfp_flash_model

// ===== dv/sector_flash_program_and_status_test.sv
// self-checking bench for the sector flash host controller
// assumes the behavioural flash model on the pins; gap and cycle limits shortened
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin samples_checked++; if ((got) !== (exp)) begin mismatches++; \
    $display("[FAIL] %s expected %h got %h", nm, exp, got); end end
module sector_flash_program_and_status_test import sfp_pkg::*; ;
    localparam logic [7:0] MK_ID = 8'h3c; // arbitrary
    localparam logic [7:0] PT_ID = 8'hc5; // arbitrary
    typedef struct {logic [15:0] data; logic err; logic [1:0] on;} sfp_note_s;
    logic clock = 1'b0, srst = 1'b1, op_valid = 1'b0, wr_valid = 1'b0, full_seen = 1'b0;
    logic [1:0] op_code = 2'h0;
    logic [ADDR_W-1:0] op_addr = '0;
    logic [7:0] op_len = 8'h00, wr_data = 8'h00;
    logic [31:0] prog_cyc = 32'h12c;
    logic op_ready, wr_ready, rsp_valid, rsp_err, fl_ce_n, fl_oe_n, fl_we_n, fl_dq_oe_n;
    logic [15:0] rsp_data;
    logic [ADDR_W-1:0] fl_addr, a;
    logic [DATA_W-1:0] fl_dq_o, fl_dq_m, wire_dq;
    int mismatches = 0, samples_checked = 0, seed = 6651, viol_cnt, rsp_seen = 0;
    sfp_note_s note_q[$];
    logic [7:0] feed_q[$];
    logic [7:0] shadow [int];
    assign wire_dq = fl_dq_oe_n ? fl_dq_m : fl_dq_o;

    sfp_host #(.GAP_CYC_P(200), .PROG_CYC_P(2000)) DUT (.clock(clock), .srst(srst), .op_valid(op_valid),
        .op_ready(op_ready), .op_code(op_code), .op_addr(op_addr), .op_len(op_len), .wr_valid(wr_valid),
        .wr_ready(wr_ready), .wr_data(wr_data), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_err(rsp_err),
        .fl_addr(fl_addr), .fl_ce_n(fl_ce_n), .fl_oe_n(fl_oe_n), .fl_we_n(fl_we_n), .fl_dq_o(fl_dq_o),
        .fl_dq_oe_n(fl_dq_oe_n), .fl_dq_i(wire_dq));
    sfp_flash_model #(.GAP_CYC_M(150), .MAKER_ID(MK_ID), .PART_ID(PT_ID)) far_end (.clock(clock),
        .busy_cyc(prog_cyc), .addr(fl_addr), .ce_n(fl_ce_n), .oe_n(fl_oe_n), .we_n(fl_we_n), .din(wire_dq),
        .dout(fl_dq_m), .viol_cnt(viol_cnt));

    initial forever #4 clock = ~clock;
    // ==========================================================
    // closing and watchdog
    task automatic close_out();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        #(8 * 60000);
        mismatches++;
        $display("[FAIL] run_end expected done got timeout");
        close_out();
    end
    // ==========================================================
    // response monitor
    always @(posedge clock) begin
        sfp_note_s n;
        if (rsp_valid === 1'b1) begin
            rsp_seen++;
            if (note_q.size() == 0) begin
                mismatches++;
                $display("[FAIL] rsp_valid expected 0 got 1");
            end else begin
                n = note_q.pop_front();
                if (n.on[0]) `CHK("rsp_data", n.data, rsp_data)
                if (n.on[1]) `CHK("rsp_err", n.err, rsp_err)
            end
        end
    end
    // ==========================================================
    // byte feeder, random idle cycles, holds until taken
    initial forever begin
        @(posedge clock);
        if (wr_valid === 1'b1 && wr_ready !== 1'b1) begin
            full_seen = 1'b1;
            continue;
        end
        if (feed_q.size() > 0 && ($random(seed) & 3) != 0) begin
            wr_data <= feed_q.pop_front();
            wr_valid <= 1'b1;
        end else wr_valid <= 1'b0;
    end
    // ==========================================================
    // operations
    function automatic logic [7:0] exp_byte(input int x);
        return shadow.exists(x) ? shadow[x] : 8'(x) ^ 8'(x >> 8) ^ 8'(x >> 16);
    endfunction
    task automatic do_op(input logic [1:0] code, input logic [ADDR_W-1:0] ad, input logic [7:0] len);
        int start;
        start = rsp_seen;
        op_code <= code;
        op_addr <= ad;
        op_len <= len;
        op_valid <= 1'b1;
        do @(posedge clock); while (op_ready !== 1'b1);
        op_valid <= 1'b0;
        for (int i = 0; i < 20000 && rsp_seen == start; i++) @(posedge clock);
        if (rsp_seen == start) begin
            mismatches++;
            $display("[FAIL] rsp_valid expected 1 got 0");
        end
        @(posedge clock);
    endtask
    task automatic read_chk(input logic [ADDR_W-1:0] ad);
        note_q.push_back('{{8'h00, exp_byte(int'(ad))}, 1'b0, 2'b11});
        do_op(2'h0, ad, 8'h00);
    endtask
    // loads nb bytes, reads them back once the flash is idle again
    task automatic prog(input logic [ADDR_W-1:0] ad, input int nb, input logic [7:0] len, input logic err,
                        input logic [1:0] on, input int settle);
        logic [7:0] b;
        for (int i = 0; i < nb; i++) begin
            b = 8'($random(seed));
            feed_q.push_back(b);
            shadow[int'(ad) + i] = b;
        end
        note_q.push_back('{{8'h00, b}, err, on});
        do_op(2'h1, ad, len);
        repeat (settle) @(posedge clock);
        prog_cyc <= 32'h12c;
        for (int i = 0; i < nb; i++) read_chk(ad + ADDR_W'(i));
    endtask
    // ==========================================================
    // main sequence
    initial begin
        repeat (16) @(posedge clock);
        srst <= 1'b0;
        @(posedge clock);
        note_q.push_back('{{MK_ID, PT_ID}, 1'b0, 2'b01});
        do_op(2'h2, '0, 8'h00);
        read_chk(17'h00000);
        read_chk(17'h00001);
        for (int k = 0; k < 3; k++) begin
            a = {1'b1, 9'($random(seed)), 7'($random(seed)) & 7'h78};
            prog(a, k + 6, 8'(k + 6), 1'b0, 2'b11, 0);
        end
        prog(17'h1f200, 1, 8'h00, 1'b0, 2'b11, 0);
        prog(17'h1e578, 8, 8'h08, 1'b0, 2'b11, 0);
        prog(17'h1d300, 2, 8'h05, 1'b1, 2'b11, 0);
        prog_cyc <= 32'hbb8;
        prog(17'h1c400, 3, 8'h03, 1'b1, 2'b10, 1500);
        for (int k = 0; k < 6; k++) read_chk(17'($random(seed)) & 17'h0ffff);
        `CHK("buffer_refused", 1'b1, full_seen)
        `CHK("far_side_order", 0, viol_cnt)
        `CHK("notes_left", 0, note_q.size())
        close_out();
    end
endmodule // sector_flash_program_and_status_test
